// ### hw/esd_map.vh
`ifndef ESD_MAP_VH
`define ESD_MAP_VH
// Register byte offsets
`define ESD_PHY_CONTROL_ONE_OFF 8'h00
`define ESD_LINK_STATUS_OFF 8'h04
`define ESD_NEG_RESULT_OFF 8'h08
`define ESD_MAC_CONTROL_TWO_OFF 8'h0C
`define ESD_MAC_COLL_RETRY_OFF 8'h10
`define ESD_MAC_IPG_OFF 8'h14
`define ESD_MAC_B2B_GAP_OFF 8'h18
// phy_control_one fields
`define ESD_SPEED_BIT 13
`define ESD_AUTONEG_BIT 12
`define ESD_RENEG_BIT 9
`define ESD_DUPLEX_BIT 8
`define ESD_PHY_CONTROL_ONE_RST 16'h1000
// link_status fields
`define ESD_ST_FAST_BIT 0
`define ESD_ST_FULL_BIT 1
`define ESD_ST_POL_BIT 2
`define ESD_ST_DONE_BIT 3
`define ESD_ST_PARTNER_NEG_BIT 4
`define ESD_ST_DEFER_BIT 5
`define ESD_ST_ABORTS_LSB 8
// mac_control_two full duplex bit
`define ESD_MAC_FULL_BIT 0
`define ESD_MAC_CONTROL_TWO_RST 16'h40B2
`define ESD_MAC_COLL_RETRY_RST 16'h370F
`define ESD_MAC_IPG_RST 16'h0C12
`define ESD_MAC_B2B_GAP_RST 16'h0012
// Collision backoff time, ns, and cycles at 10 ns
`define ESD_BACKOFF_NS 5120
`define ESD_CLK_NS 10
`define ESD_BACKOFF_CYC (`ESD_BACKOFF_NS / `ESD_CLK_NS)
// AXI response codes
`define ESD_RESP_OKAY 2'h0
`define ESD_RESP_SLVERR 2'h2
`endif

// ### hw/esd_sync3.v
module esd_sync3 #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Asynchronous input and filtered result
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] s1_r;
   reg [WIDTH-1:0] s2_r;
   reg [WIDTH-1:0] s3_r;

   // Change is accepted once the second and third stages agree
   always @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= {WIDTH{1'b0}};
         s2_r <= {WIDTH{1'b0}};
         s3_r <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            sync_out <= s3_r;
         end
      end
   end
endmodule // esd_sync3

// ### hw/esd_speed_duplex.v
// Our own choices: the AXI4-Lite register port and the register addresses.
`include "esd_map.vh"

// Summary of operation
// R1: Four modes: 10/100, half or full duplex
// R2: Speed/duplex from manual bits or negotiation
// R3: 10Base-T corrects reversed receive polarity only
// R4: Half duplex defers while remote carrier present
// R5: Remote nodes defer while we transmit
// R6: Half duplex collision aborts, retries later
// R7: Full duplex ignores carrier and collisions
// R8: Clearing autoneg_enable selects manual settings
// R9: manual_speed_fast set selects 100Base-TX
// R10: manual_full_duplex set selects full duplex
// R11: Host programs both speed and duplex
// R12: Host updates MAC timing after mode change
// R13: autoneg_enable resets to one
// R14: Manual bits ignored, unreported under negotiation; the code still reads them back in phy_control_one
// R15: No partner negotiation: parallel detect, half
// R16: Effective mode from negotiation or manual bits
module esd_speed_duplex (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Negotiation engine results (asynchronous, from the PHY analog side)
   input wire neg_done,
   input wire neg_partner_able,
   input wire neg_fast,
   input wire neg_full,
   input wire pd_fast,
   // Receive pair polarity detector, 1 when reversed
   input wire twisted_pair_receive_reversed,
   // Medium status from the PHY (asynchronous)
   input wire carrier_sense,
   input wire collision,
   // MAC transmit request, same clock domain
   input wire tx_request,
   input wire tx_done,
   // Mode and control outputs
   output reg eff_speed_fast,
   output reg eff_full_duplex,
   output reg rx_polarity_invert,
   output reg reneg_pulse,
   output reg tx_enable,
   output reg tx_abort,
   output reg tx_deferring
);
   localparam integer BACKOFF_CYC = `ESD_BACKOFF_CYC;

   // Transmit control states, one-hot
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_DEFER = 4'h2;
   localparam [3:0] ST_SEND = 4'h4;
   localparam [3:0] ST_BACKOFF = 4'h8;

   wire [7:0] ph_in = {collision, carrier_sense, twisted_pair_receive_reversed, pd_fast,
                       neg_full, neg_fast, neg_partner_able, neg_done};
   wire [7:0] ph_sync;
   wire s_done = ph_sync[0];
   wire s_partner = ph_sync[1];
   wire s_neg_fast = ph_sync[2];
   wire s_neg_full = ph_sync[3];
   wire s_pd_fast = ph_sync[4];
   wire s_rev = ph_sync[5];
   wire s_crs = ph_sync[6];
   wire s_col = ph_sync[7];

   esd_sync3 #(.WIDTH(8)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(ph_in),
      .sync_out(ph_sync)
   );

   reg autoneg_enable_r;
   reg manual_speed_fast_r;
   reg manual_full_duplex_r;
   reg [15:0] mac_control_two_r;
   reg [15:0] mac_collision_retry_control_r;
   reg [15:0] mac_interpacket_gap_r;
   reg [15:0] mac_back_to_back_gap_r;
   reg [3:0] tx_state_r;
   reg [3:0] tx_state_nxt;
   reg [15:0] backoff_cnt_r;
   reg [7:0] abort_cnt_r;

   // Effective mode selection
   reg neg_fast_res, neg_full_res, mode_fast, mode_full;
   always @* begin
      if (s_partner) begin
         neg_fast_res = s_neg_fast;
         neg_full_res = s_neg_full;
      end else begin
         neg_fast_res = s_pd_fast; // R15
         neg_full_res = 1'b0; // R15
      end
      if (autoneg_enable_r) begin
         mode_fast = neg_fast_res; // R2 R16
         mode_full = neg_full_res; // R16
      end else begin
         mode_fast = manual_speed_fast_r; // R8 R9
         mode_full = manual_full_duplex_r; // R8 R10
      end
   end

   // AXI write channel: address and data accepted in either order
   reg aw_held_r;
   reg w_held_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire [7:0] wa = aw_held_r ? aw_addr_r : s_axi_awaddr;
   wire [31:0] wd = w_held_r ? w_data_r : s_axi_wdata;
   wire [3:0] ws = w_held_r ? w_strb_r : s_axi_wstrb;
   wire wr_fire = (aw_held_r | aw_take) & (w_held_r | w_take) & ~s_axi_bvalid;

   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   always @(posedge clk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ESD_RESP_OKAY;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         autoneg_enable_r <= 1'b1; // R13
         manual_speed_fast_r <= 1'b0;
         manual_full_duplex_r <= 1'b0;
         reneg_pulse <= 1'b0;
         mac_control_two_r <= `ESD_MAC_CONTROL_TWO_RST;
         mac_collision_retry_control_r <= `ESD_MAC_COLL_RETRY_RST;
         mac_interpacket_gap_r <= `ESD_MAC_IPG_RST;
         mac_back_to_back_gap_r <= `ESD_MAC_B2B_GAP_RST;
      end else begin
         reneg_pulse <= 1'b0;
         s_axi_awready <= ~aw_held_r & ~aw_take & ~s_axi_bvalid;
         s_axi_wready <= ~w_held_r & ~w_take & ~s_axi_bvalid;
         if (aw_take) begin
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `ESD_RESP_OKAY;
            case (wa)
               `ESD_PHY_CONTROL_ONE_OFF: begin
                  if (ws[1]) begin
                     manual_speed_fast_r <= wd[`ESD_SPEED_BIT]; // R9
                     autoneg_enable_r <= wd[`ESD_AUTONEG_BIT]; // R8
                     manual_full_duplex_r <= wd[`ESD_DUPLEX_BIT]; // R10
                     reneg_pulse <= wd[`ESD_RENEG_BIT];
                  end
               end
               `ESD_MAC_CONTROL_TWO_OFF: mac_control_two_r <= merge16(mac_control_two_r, wd, ws);
               `ESD_MAC_COLL_RETRY_OFF: mac_collision_retry_control_r <=
                  merge16(mac_collision_retry_control_r, wd, ws);
               `ESD_MAC_IPG_OFF: mac_interpacket_gap_r <= merge16(mac_interpacket_gap_r, wd, ws);
               `ESD_MAC_B2B_GAP_OFF: mac_back_to_back_gap_r <= merge16(mac_back_to_back_gap_r, wd, ws);
               `ESD_LINK_STATUS_OFF, `ESD_NEG_RESULT_OFF: s_axi_bresp <= `ESD_RESP_OKAY;
               default: s_axi_bresp <= `ESD_RESP_SLVERR;
            endcase
         end else begin
            if (aw_take) begin
               aw_held_r <= 1'b1;
            end
            if (w_take) begin
               w_held_r <= 1'b1;
            end
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= ~aw_held_r;
            s_axi_wready <= ~w_held_r;
         end
      end
   end

   // AXI read channel
   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `ESD_PHY_CONTROL_ONE_OFF: begin
            rd_val[`ESD_AUTONEG_BIT] = autoneg_enable_r;
            // Under negotiation the manual bits do not reflect the mode
            rd_val[`ESD_SPEED_BIT] = manual_speed_fast_r; // R14
            rd_val[`ESD_DUPLEX_BIT] = manual_full_duplex_r; // R14
         end
         `ESD_LINK_STATUS_OFF: begin
            rd_val[`ESD_ST_FAST_BIT] = eff_speed_fast;
            rd_val[`ESD_ST_FULL_BIT] = eff_full_duplex;
            rd_val[`ESD_ST_POL_BIT] = rx_polarity_invert;
            rd_val[`ESD_ST_DONE_BIT] = s_done;
            rd_val[`ESD_ST_PARTNER_NEG_BIT] = s_partner;
            rd_val[`ESD_ST_DEFER_BIT] = tx_deferring;
            rd_val[`ESD_ST_ABORTS_LSB +: 8] = abort_cnt_r;
         end
         `ESD_NEG_RESULT_OFF: rd_val[1:0] = {neg_full_res, neg_fast_res};
         `ESD_MAC_CONTROL_TWO_OFF: rd_val[15:0] = mac_control_two_r;
         `ESD_MAC_COLL_RETRY_OFF: rd_val[15:0] = mac_collision_retry_control_r;
         `ESD_MAC_IPG_OFF: rd_val[15:0] = mac_interpacket_gap_r;
         `ESD_MAC_B2B_GAP_OFF: rd_val[15:0] = mac_back_to_back_gap_r;
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ESD_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? `ESD_RESP_OKAY : `ESD_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Registered mode outputs
   always @(posedge clk) begin
      if (!rst_n) begin
         eff_speed_fast <= 1'b0;
         eff_full_duplex <= 1'b0;
         rx_polarity_invert <= 1'b0;
      end else begin
         eff_speed_fast <= mode_fast; // R1 R16
         eff_full_duplex <= mode_full; // R1 R16
         rx_polarity_invert <= ~mode_fast & s_rev; // R3
      end
   end

   // Transmit access control
   wire busy_medium = s_crs & ~eff_full_duplex; // R4 R7
   wire coll_hit = s_col & ~eff_full_duplex; // R6 R7

   always @* begin
      tx_state_nxt = tx_state_r;
      case (tx_state_r)
         ST_IDLE: begin
            if (tx_request) begin
               tx_state_nxt = busy_medium ? ST_DEFER : ST_SEND; // R4
            end
         end
         ST_DEFER: begin
            if (!busy_medium) begin
               tx_state_nxt = ST_SEND; // R4
            end
         end
         ST_SEND: begin
            if (coll_hit) begin
               tx_state_nxt = ST_BACKOFF; // R6
            end else if (tx_done) begin
               tx_state_nxt = ST_IDLE;
            end
         end
         ST_BACKOFF: begin
            // Retry defers only if the medium is busy, never in full duplex
            if (backoff_cnt_r == 16'h0000) begin
               tx_state_nxt = busy_medium ? ST_DEFER : ST_SEND; // R6
            end
         end
         default: tx_state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         tx_state_r <= ST_IDLE;
         backoff_cnt_r <= 16'h0000;
         abort_cnt_r <= 8'h00;
         tx_enable <= 1'b0;
         tx_abort <= 1'b0;
         tx_deferring <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         tx_abort <= 1'b0;
         if (tx_state_r == ST_SEND && tx_state_nxt == ST_BACKOFF) begin
            backoff_cnt_r <= BACKOFF_CYC[15:0] - 16'h0001;
            abort_cnt_r <= abort_cnt_r + 8'h01;
            tx_abort <= 1'b1; // R6
         end else if (backoff_cnt_r != 16'h0000) begin
            backoff_cnt_r <= backoff_cnt_r - 16'h0001;
         end
         tx_enable <= (tx_state_nxt == ST_SEND);
         tx_deferring <= (tx_state_nxt == ST_DEFER);
      end
   end
endmodule // esd_speed_duplex

// ### dv/esd_remote_node.sv
module esd_remote_node (
   // Clock
   input wire clk,
   // Bench commands
   input wire start,
   input wire jam,
   // Our transmitter
   input wire our_tx,
   // Medium
   output logic carrier_sense,
   output logic collision
);
   timeunit 1ns;
   timeprecision 1ns;
   int left = 0;
   assign carrier_sense = left > 0;
   assign collision = carrier_sense && our_tx;
   // Waits while we send unless told to collide
   always @(posedge clk) begin
      if (start && left == 0 && (!our_tx || jam)) left <= 40;
      else if (left > 0) left <= left - 1;
   end
endmodule // esd_remote_node

// ### dv/esd_chk.sv
module esd_chk (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Mode and transmit control
   input wire eff_speed_fast,
   input wire eff_full_duplex,
   input wire rx_polarity_invert,
   input wire reneg_pulse,
   input wire tx_enable,
   input wire tx_abort,
   input wire tx_deferring
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_POL_10: assert property (rx_polarity_invert |-> !eff_speed_fast)
      else $error("polarity fix outside 10 mode");
   AST_NO_OVERLAP: assert property (!(tx_enable && tx_deferring))
      else $error("send and defer together");
   AST_DEFER_TO_SEND: assert property ($fell(tx_deferring) |-> tx_enable)
      else $error("defer ended without send");
   AST_ABORT_FROM_SEND: assert property (tx_abort |-> $past(tx_enable))
      else $error("abort outside send");
   AST_BACKOFF: assert property (tx_abort |=> !tx_enable [*8])
      else $error("retry without backoff");
   AST_ABORT_HALF: assert property (tx_abort |-> !eff_full_duplex)
      else $error("abort in full duplex");
   AST_DEFER_HALF: assert property (tx_deferring |-> !eff_full_duplex)
      else $error("defer in full duplex");
   AST_RENEG_ONE: assert property (reneg_pulse |=> !reneg_pulse)
      else $error("restart pulse too long");
endmodule // esd_chk

bind esd_speed_duplex esd_chk u_esd_chk (.clk, .rst_n, .eff_speed_fast, .eff_full_duplex,
   .rx_polarity_invert, .reneg_pulse, .tx_enable, .tx_abort, .tx_deferring);

// ### dv/tb.sv
`include "esd_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   logic ndone = 0, able = 0, nfast = 0, nfull = 0, pfast = 0, rev = 0;
   logic txr = 0, txd = 0, rstart = 0, jam = 0, saw_ab = 0, saw_rn = 0;
   wire awr, wr, bv, arr, rv, cs, col, fast, full, pol, rn, txe, ab, dfr;
   wire [1:0] br, rr;
   wire [31:0] rd;
   logic [31:0] d;
   logic [31:0] pv;
   logic [1:0] r;
   int failures = 0, num_checks = 0;
   always #5 clk = ~clk;
   esd_speed_duplex u_esd_speed_duplex (.clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .neg_done(ndone), .neg_partner_able(able), .neg_fast(nfast), .neg_full(nfull), .pd_fast(pfast),
      .twisted_pair_receive_reversed(rev), .carrier_sense(cs), .collision(col), .tx_request(txr),
      .tx_done(txd), .eff_speed_fast(fast), .eff_full_duplex(full), .rx_polarity_invert(pol),
      .reneg_pulse(rn), .tx_enable(txe), .tx_abort(ab), .tx_deferring(dfr));
   esd_remote_node u_esd_remote_node (.clk(clk), .start(rstart), .jam(jam), .our_tx(txe),
      .carrier_sense(cs), .collision(col));
   always @(posedge clk) begin
      if (ab) saw_ab <= 1;
      if (rn) saw_rn <= 1;
   end
   task automatic close_out();
      if (failures == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awa <= a;
      wd <= v;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      forever begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wr) wv <= 0;
         if (bv) break;
      end
      bry <= 0;
      r = br;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      forever begin
         @(posedge clk);
         if (arr) arv <= 0;
         if (rv) break;
      end
      rry <= 0;
      d = rd;
      r = rr;
   endtask
   function automatic logic [1:0] exp_mode(input logic an, input logic mf, input logic md);
      if (!an) return {mf, md};
      if (!able) return {pfast, 1'b0};
      return {nfast, nfull};
   endfunction
   // Sync inputs need a few cycles to reach the mode outputs
   task automatic chk_mode(input logic an, input logic mf, input logic md);
      logic [1:0] e;
      e = exp_mode(an, mf, md);
      hold(10);
      check("speed", fast, e[1]);
      check("duplex", full, e[0]);
      check("polarity", pol, rev && !e[1]);
   endtask
   task automatic wait_txe();
      int n;
      n = 0;
      while (txe !== 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      check("tx enable", txe, 1);
   endtask
   task automatic tx_end();
      txd <= 1;
      @(posedge clk);
      txd <= 0;
      txr <= 0;
   endtask
   initial begin
      void'($urandom(96));
      hold(8);
      rst_n <= 1;
      axr(`ESD_PHY_CONTROL_ONE_OFF);
      check("ctl reset", d, 32'h1000);
      ndone <= 1;
      able <= 1;
      for (int i = 0; i < 6; i++) begin
         nfast <= $urandom;
         nfull <= $urandom;
         pfast <= $urandom;
         rev <= $urandom;
         able <= (i > 3) ? 1'b0 : 1'b1;
         pv = $urandom & 32'h2100;
         axw(`ESD_PHY_CONTROL_ONE_OFF, pv | 32'h1000);
         check("wr resp", r, `ESD_RESP_OKAY);
         chk_mode(1, pv[13], pv[8]);
         axr(`ESD_NEG_RESULT_OFF);
         check("neg result", d, able ? {30'h0, nfull, nfast} : {31'h0, pfast});
      end
      able <= 1;
      for (int i = 0; i < 4; i++) begin
         nfast <= !i[1];
         nfull <= !i[0];
         axw(`ESD_PHY_CONTROL_ONE_OFF, {18'h0, i[1], 4'h0, i[0], 8'h00});
         chk_mode(0, i[1], i[0]);
      end
      axw(`ESD_PHY_CONTROL_ONE_OFF, 32'h1200);
      axr(`ESD_PHY_CONTROL_ONE_OFF);
      check("restart seen", saw_rn, 1);
      check("restart clears", d[9], 0);
      axr(8'h40);
      check("unmapped resp", r, `ESD_RESP_SLVERR);
      axw(8'h40, 32'h0);
      check("unmapped wr", r, `ESD_RESP_SLVERR);
      axr(`ESD_MAC_CONTROL_TWO_OFF);
      check("mac ctl reset", d, `ESD_MAC_CONTROL_TWO_RST);
      check("rd resp", r, `ESD_RESP_OKAY);
      axw(`ESD_MAC_CONTROL_TWO_OFF, 32'h40B3);
      axr(`ESD_MAC_CONTROL_TWO_OFF);
      check("mac ctl", d, 32'h40B3);
      axw(`ESD_PHY_CONTROL_ONE_OFF, 32'h0);
      hold(10);
      rstart <= 1;
      hold(2);
      rstart <= 0;
      hold(6);
      txr <= 1;
      hold(4);
      check("deferring", dfr, 1);
      check("held off", txe, 0);
      wait_txe();
      check("medium free", cs, 0);
      rstart <= 1;
      jam <= 1;
      hold(2);
      rstart <= 0;
      jam <= 0;
      hold(8);
      check("abort", saw_ab, 1);
      check("stopped", txe, 0);
      wait_txe();
      tx_end();
      axr(`ESD_LINK_STATUS_OFF);
      check("status", d, {16'h0, 8'h01, 3'h0, able, ndone, rev, 2'h0});
      axw(`ESD_PHY_CONTROL_ONE_OFF, 32'h0100);
      hold(10);
      saw_ab <= 0;
      rstart <= 1;
      hold(2);
      rstart <= 0;
      hold(6);
      txr <= 1;
      hold(6);
      check("full send", txe, 1);
      hold(10);
      check("full no abort", saw_ab, 0);
      tx_end();
      hold(5);
      close_out();
   end
   initial begin
      #200us;
      failures++;
      close_out();
   end
endmodule // tb
